// >>> hdl/rpc_regs.svh
`ifndef RPC_REGS_SVH
`define RPC_REGS_SVH

// Register byte offsets
`define RPC_CFG_BASE      8'h00
`define RPC_CTRL_OFS      8'h20
`define RPC_STAT_OFS      8'h24
`define RPC_MODE_OFS      8'h28
`define RPC_IMP_BASE      8'h40
`define RPC_CHAN_SPAN     8'h20

// Channel config fields
`define RPC_CFG_RES       1:0
`define RPC_CFG_TER       3:2
`define RPC_CFG_RST       4'h0

// Control fields
`define RPC_CTRL_MUTE     0
`define RPC_CTRL_EDGE     1
`define RPC_MUTE_RST      1'b1
`define RPC_EDGE_RST      1'b0

// Mode and status fields
`define RPC_MODE_HOST     0
`define RPC_MODE_CHG      1
`define RPC_MODE_BUS      7:4
`define RPC_STAT_LOS      7:0
`define RPC_STAT_MUTED    15:8

// Pull levels of undriven pins
`define RPC_PULL_MUTE     1'b1
`define RPC_PULL_RES      2'h0
`define RPC_PULL_EDGE     1'b0

// Resistor select codes
`define RPC_RES_NONE      2'h0
`define RPC_RES_240       2'h1
`define RPC_RES_210       2'h2
`define RPC_RES_150       2'h3

// Impedances in ohms
`define RPC_OHM_240       16'h00f0
`define RPC_OHM_210       16'h00d2
`define RPC_OHM_150       16'h0096
`define RPC_OHM_75        16'h004b
`define RPC_OHM_100       16'h0064
`define RPC_OHM_110       16'h006e
`define RPC_OHM_120       16'h0078

`endif

// >>> hdl/rpc_pkg.sv
package rpc_pkg;

  typedef enum logic [3:0] {
    RPC_BUS_ASYNC_A = 4'h1,
    RPC_BUS_ASYNC_B = 4'h2,
    RPC_BUS_SYNC_A  = 4'h4,
    RPC_BUS_SYNC_B  = 4'h8
  } rpc_bus_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } rpc_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } rpc_apb_rsp_s;

  typedef struct packed {
    logic clk_prev;
    logic pos;
    logic neg;
    logic muted;
  } rpc_chan_st_s;

  typedef struct packed {
    logic [7:0][3:0] cfg;
    logic            mute_en;
    logic            edge_fall;
    logic [8:0]      pins_prev;
    logic            primed;
    logic            cfg_changed;
    rpc_bus_e        bus_type;
    logic [31:0]     prdata;
    logic            pslverr;
  } rpc_top_st_s;

endpackage : rpc_pkg

// >>> hdl/rpc_chan.sv
`timescale 1ns/10ps
module rpc_chan (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic rx_rec_clk,
  input  wire logic rx_pos_data_in,
  input  wire logic rx_neg_data_in,
  input  wire logic rx_loss_of_signal,
  input  wire logic mute_on,
  input  wire logic fall_edge,
  output logic      rx_pos_data_out,
  output logic      rx_neg_data_out,
  output logic      muted
);
  import rpc_pkg::*;

  rpc_chan_st_s st;
  rpc_chan_st_s next_st;
  logic         upd;

  always_comb begin
    next_st = st;
    upd = 1'b0;
    next_st.clk_prev = rx_rec_clk;
    if (fall_edge) begin
      upd = st.clk_prev & ~rx_rec_clk;
    end else begin
      upd = ~st.clk_prev & rx_rec_clk;
    end
    if (mute_on && rx_loss_of_signal) begin
      next_st.pos = 1'b0;
      next_st.neg = 1'b0;
      next_st.muted = 1'b1;
    end else begin
      next_st.muted = 1'b0;
      if (upd) begin
        next_st.pos = rx_pos_data_in;
        next_st.neg = rx_neg_data_in;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rx_pos_data_out = st.pos;
  assign rx_neg_data_out = st.neg;
  assign muted           = st.muted;
endmodule : rpc_chan

// >>> hdl/rpc_imp.sv
`timescale 1ns/10ps
`include "rpc_regs.svh"
module rpc_imp (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic [1:0]  res_sel,
  input  wire logic [1:0]  ter_sel,
  output logic      [15:0] int_ohms
);
  import rpc_pkg::*;

  logic [15:0] st;
  logic [15:0] next_st;

  function automatic logic [15:0] ter_ohms(input logic [1:0] sel);
    case (sel)
      2'h0:    ter_ohms = `RPC_OHM_75;
      2'h1:    ter_ohms = `RPC_OHM_100;
      2'h2:    ter_ohms = `RPC_OHM_110;
      default: ter_ohms = `RPC_OHM_120;
    endcase
  endfunction : ter_ohms

  function automatic logic [15:0] ext_ohms(input logic [1:0] sel);
    case (sel)
      `RPC_RES_240: ext_ohms = `RPC_OHM_240;
      `RPC_RES_210: ext_ohms = `RPC_OHM_210;
      `RPC_RES_150: ext_ohms = `RPC_OHM_150;
      default:      ext_ohms = 16'h0000;
    endcase
  endfunction : ext_ohms

  function automatic logic [15:0] match(input logic [1:0] rs, input logic [1:0] ts);
    logic [31:0] re;
    logic [31:0] rt;
    logic [31:0] q;
    re = {16'h0000, ext_ohms(rs)};
    rt = {16'h0000, ter_ohms(ts)};
    q = 32'h0000_0000;
    if (rs == `RPC_RES_NONE) begin
      q = rt;
    end else begin
      q = (re * rt) / (re - rt);
    end
    match = q[15:0];
  endfunction : match

  always_comb begin
    next_st = match(res_sel, ter_sel);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign int_ohms = st;
endmodule : rpc_imp

// >>> hdl/rpc_top.sv
// What this block does
// - Hardware mode: mute high and loss of signal force both rx outputs low.
// - Mute low leaves rx outputs unmuted whatever the loss of signal.
// - Undriven mute pin reads as high, so muting is on by default.
// - Resistor select: 00 none, 01 240, 10 210, 11 150 ohms.
// - Internal impedance in parallel with external resistor equals termination impedance.
// - Undriven resistor select pins read as low, meaning no external resistor.
// - Host mode takes each channel's resistor select from its register.
// - Hardware mode: edge select low updates on rising, high on falling edge.
// - Host mode: bus type 00/01 asynchronous styles, 10/11 synchronous styles.
// - Undriven edge select reads as low, giving rising edge updates.
`timescale 1ns/10ps
`include "rpc_regs.svh"
module rpc_top (
  input  wire logic                  sys_clk,
  input  wire logic                  arst_n,
  input  wire rpc_pkg::rpc_apb_req_s apb_req,
  output rpc_pkg::rpc_apb_rsp_s      apb_rsp,
  input  wire logic                  host_mode,
  input  wire logic                  rx_mute_enable,
  input  wire logic                  rx_mute_enable_drv,
  input  wire logic [1:0]            rx_ext_resistor_sel,
  input  wire logic                  rx_ext_resistor_sel_drv,
  input  wire logic [1:0]            termination_impedance_sel,
  input  wire logic                  rx_clock_edge_sel,
  input  wire logic                  rx_clock_edge_sel_drv,
  input  wire logic                  tx_clock_edge_sel,
  input  wire logic                  tx_clock_edge_sel_drv,
  input  wire logic [7:0]            rx_rec_clk,
  input  wire logic [7:0]            rx_pos_data_in,
  input  wire logic [7:0]            rx_neg_data_in,
  input  wire logic [7:0]            rx_loss_of_signal,
  output logic      [7:0]            rx_pos_data_out,
  output logic      [7:0]            rx_neg_data_out,
  output logic      [7:0][1:0]       chan_ter_sel,
  output rpc_pkg::rpc_bus_e          host_bus_type_sel,
  output logic                       reconfig_seen
);
  import rpc_pkg::*;

  rpc_top_st_s      st;
  rpc_top_st_s      next_st;

  logic             mute_pin;
  logic [1:0]       res_pin;
  logic             edge_pin;
  logic             tx_pin;
  logic             mute_on;
  logic             fall_edge;
  logic [7:0][1:0]  res_eff;
  logic [7:0][1:0]  ter_eff;
  logic [7:0]       muted;
  logic [7:0][15:0] int_ohms;
  logic [8:0]       pins_now;
  logic             setup;
  logic             access;

  // Decode of host bus style
  function automatic rpc_bus_e bus_decode(input logic [1:0] code);
    case (code)
      2'h0:    bus_decode = RPC_BUS_ASYNC_A;
      2'h1:    bus_decode = RPC_BUS_ASYNC_B;
      2'h2:    bus_decode = RPC_BUS_SYNC_A;
      default: bus_decode = RPC_BUS_SYNC_B;
    endcase
  endfunction : bus_decode

  // Channel index within a block of eight words
  function automatic logic [2:0] chan_of(input logic [7:0] addr);
    chan_of = addr[4:2];
  endfunction : chan_of

  // True when the address lies in a per-channel block
  function automatic logic in_block(input logic [7:0] addr, input logic [7:0] base);
    in_block = (addr >= base) && (addr < (base + `RPC_CHAN_SPAN))
               && (addr[1:0] == 2'h0);
  endfunction : in_block

  // Strap pins with their pull levels
  always_comb begin
    mute_pin = `RPC_PULL_MUTE;
    if (rx_mute_enable_drv) begin
      mute_pin = rx_mute_enable;
    end
    res_pin = `RPC_PULL_RES;
    if (rx_ext_resistor_sel_drv) begin
      res_pin = rx_ext_resistor_sel;
    end
    edge_pin = `RPC_PULL_EDGE;
    if (rx_clock_edge_sel_drv) begin
      edge_pin = rx_clock_edge_sel;
    end
    tx_pin = `RPC_PULL_EDGE;
    if (tx_clock_edge_sel_drv) begin
      tx_pin = tx_clock_edge_sel;
    end
  end

  // Mode selection of effective settings
  always_comb begin
    if (host_mode) begin
      mute_on   = st.mute_en;
      fall_edge = st.edge_fall;
    end else begin
      mute_on   = mute_pin;
      fall_edge = edge_pin;
    end
    for (int i = 0; i < 8; i++) begin
      if (host_mode) begin
        res_eff[i] = st.cfg[i][`RPC_CFG_RES];
        ter_eff[i] = st.cfg[i][`RPC_CFG_TER];
      end else begin
        res_eff[i] = res_pin;
        ter_eff[i] = termination_impedance_sel;
      end
    end
  end

  assign pins_now = {host_mode, mute_pin, res_pin, edge_pin, tx_pin,
                     termination_impedance_sel, 1'b0};
  assign setup    = apb_req.psel & ~apb_req.penable;
  assign access   = apb_req.psel & apb_req.penable;

  // Register state
  always_comb begin
    next_st = st;
    next_st.pins_prev = pins_now;
    next_st.primed = 1'b1;
    if (host_mode) begin
      next_st.bus_type = bus_decode({tx_pin, edge_pin});
    end

    // Read data is captured in the setup cycle
    if (setup) begin
      next_st.prdata  = 32'h0000_0000;
      next_st.pslverr = 1'b0;
      if (in_block(apb_req.paddr, `RPC_CFG_BASE)) begin
        next_st.prdata[3:0] = st.cfg[chan_of(apb_req.paddr)];
      end else if (apb_req.paddr == `RPC_CTRL_OFS) begin
        next_st.prdata[`RPC_CTRL_MUTE] = st.mute_en;
        next_st.prdata[`RPC_CTRL_EDGE] = st.edge_fall;
      end else if (apb_req.paddr == `RPC_STAT_OFS) begin
        next_st.prdata[`RPC_STAT_LOS]   = rx_loss_of_signal;
        next_st.prdata[`RPC_STAT_MUTED] = muted;
      end else if (apb_req.paddr == `RPC_MODE_OFS) begin
        next_st.prdata[`RPC_MODE_HOST] = host_mode;
        next_st.prdata[`RPC_MODE_CHG]  = st.cfg_changed;
        next_st.prdata[`RPC_MODE_BUS]  = st.bus_type;
      end else if (in_block(apb_req.paddr, `RPC_IMP_BASE)) begin
        next_st.prdata[15:0] = int_ohms[chan_of(apb_req.paddr)];
      end else begin
        next_st.pslverr = 1'b1;
      end
    end

    // Writes take effect at the end of the access cycle
    if (access && apb_req.pwrite && !st.pslverr) begin
      if (in_block(apb_req.paddr, `RPC_CFG_BASE)) begin
        next_st.cfg[chan_of(apb_req.paddr)] = apb_req.pwdata[3:0];
      end else if (apb_req.paddr == `RPC_CTRL_OFS) begin
        next_st.mute_en   = apb_req.pwdata[`RPC_CTRL_MUTE];
        next_st.edge_fall = apb_req.pwdata[`RPC_CTRL_EDGE];
      end else if (apb_req.paddr == `RPC_MODE_OFS) begin
        if (apb_req.pwdata[`RPC_MODE_CHG]) begin
          next_st.cfg_changed = 1'b0;
        end
      end
    end

    // A strap change is a reconfiguration; set wins over clear
    if (st.primed && (pins_now != st.pins_prev)) begin
      next_st.cfg_changed = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st           <= '0;
      st.cfg       <= {8{`RPC_CFG_RST}};
      st.mute_en   <= `RPC_MUTE_RST;
      st.edge_fall <= `RPC_EDGE_RST;
      st.bus_type  <= RPC_BUS_ASYNC_A;
    end else begin
      st <= next_st;
    end
  end

  // Per-channel receive data path and impedance match
  for (genvar g = 0; g < 8; g++) begin : g_chan
    rpc_chan u_chan (
      .sys_clk           (sys_clk),
      .arst_n            (arst_n),
      .rx_rec_clk        (rx_rec_clk[g]),
      .rx_pos_data_in    (rx_pos_data_in[g]),
      .rx_neg_data_in    (rx_neg_data_in[g]),
      .rx_loss_of_signal (rx_loss_of_signal[g]),
      .mute_on           (mute_on),
      .fall_edge         (fall_edge),
      .rx_pos_data_out   (rx_pos_data_out[g]),
      .rx_neg_data_out   (rx_neg_data_out[g]),
      .muted             (muted[g])
    );
    rpc_imp u_imp (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .res_sel  (res_eff[g]),
      .ter_sel  (ter_eff[g]),
      .int_ohms (int_ohms[g])
    );
  end

  // Bus answer
  always_comb begin
    apb_rsp.prdata  = st.prdata;
    apb_rsp.pready  = access;
    apb_rsp.pslverr = access & st.pslverr;
  end

  assign chan_ter_sel      = ter_eff;
  assign host_bus_type_sel = st.bus_type;
  assign reconfig_seen     = st.cfg_changed;
endmodule : rpc_top

// >>> testbench/rpc_monitor.sv
`timescale 1ns/10ps
module rpc_monitor (
  input wire logic              sys_clk,
  input wire logic              arst_n,
  input wire logic              host_mode,
  input wire logic              rx_mute_enable,
  input wire logic              rx_mute_enable_drv,
  input wire logic              rx_clock_edge_sel,
  input wire logic              rx_clock_edge_sel_drv,
  input wire logic              tx_clock_edge_sel,
  input wire logic              tx_clock_edge_sel_drv,
  input wire logic [7:0]        rx_rec_clk,
  input wire logic [7:0]        rx_pos_data_in,
  input wire logic [7:0]        rx_neg_data_in,
  input wire logic [7:0]        rx_loss_of_signal,
  input wire logic [7:0]        rx_pos_data_out,
  input wire logic [7:0]        rx_neg_data_out,
  input wire rpc_pkg::rpc_bus_e host_bus_type_sel,
  input wire logic              reconfig_seen
);
  import rpc_pkg::*;
  logic       m_eff;
  logic       e_eff;
  logic       hw;
  logic [1:0] bt;
  logic [1:0] d0;
  assign m_eff = rx_mute_enable_drv ? rx_mute_enable : 1'b1;
  assign e_eff = rx_clock_edge_sel_drv & rx_clock_edge_sel;
  assign hw    = ~host_mode;
  assign bt    = {tx_clock_edge_sel_drv & tx_clock_edge_sel, e_eff};
  assign d0    = {rx_pos_data_in[0], rx_neg_data_in[0]};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_mute_hw;
    (hw && m_eff) [*2];
  endsequence
  sequence s_open_hw;
    (hw && !(m_eff && rx_loss_of_signal[0])) [*2];
  endsequence
  a_mute_los: assert property (s_mute_hw |=>
    ((rx_pos_data_out | rx_neg_data_out) & $past(rx_loss_of_signal)) == 8'h00)
    else $error("los output not muted");
  a_mute_default: assert property ((hw && !rx_mute_enable_drv) [*2]
    ##0 rx_loss_of_signal[0] |=> !rx_pos_data_out[0] && !rx_neg_data_out[0])
    else $error("undriven mute not active");
  a_unmute_pass: assert property ((hw && !m_eff) [*2]
    ##0 (!e_eff && $rose(rx_rec_clk[0])) |=> rx_pos_data_out[0] == $past(d0[1]))
    else $error("unmuted data lost");
  a_rise_update: assert property (s_open_hw ##0
    (!e_eff && $rose(rx_rec_clk[0])) |=> {rx_pos_data_out[0], rx_neg_data_out[0]} == $past(d0))
    else $error("rising update wrong");
  a_fall_update: assert property (s_open_hw ##0
    (e_eff && $fell(rx_rec_clk[0])) |=> {rx_pos_data_out[0], rx_neg_data_out[0]} == $past(d0))
    else $error("falling update wrong");
  a_idle_hold: assert property (s_open_hw ##0
    !(e_eff ? $fell(rx_rec_clk[0]) : $rose(rx_rec_clk[0])) |=> $stable(rx_pos_data_out[0]))
    else $error("output moved without edge");
  a_bus_style: assert property ($past(host_mode) |->
    host_bus_type_sel == (4'h1 << $past(bt)))
    else $error("bus type wrong");
  a_reconfig_flag: assert property ($past(arst_n) && $changed(host_mode)
    |-> ##[1:2] reconfig_seen)
    else $error("reconfig not flagged");
endmodule : rpc_monitor

// >>> testbench/rpc_strap.sv
`timescale 1ns/10ps
module rpc_strap (
  input  wire logic       sys_clk,
  input  wire logic [4:0] want,
  input  wire logic [3:0] drv,
  output logic      [4:0] pins,
  output logic      [3:0] drv_o
);
  import rpc_pkg::*;
  logic [4:0] mask;
  logic [4:0] lvl = 5'h00;
  logic [3:0] dq  = 4'h0;
  assign mask  = {drv[3], drv[2], drv[1], drv[1], drv[0]};
  assign pins  = lvl;
  assign drv_o = dq;
  // Floating pins toggle; driven ones change only on command
  always @(posedge sys_clk) begin
    lvl <= (want & mask) | (~lvl & ~mask);
    dq  <= drv;
  end
endmodule : rpc_strap

// >>> testbench/tb_rpc_top.sv
`timescale 1ns/10ps
module tb_rpc_top;
  import rpc_pkg::*;
  logic              sys_clk, arst_n, host_mode, reconfig;
  rpc_apb_req_s      apb_req;
  rpc_apb_rsp_s      apb_rsp;
  logic [4:0]        want, pins;
  logic [3:0]        drv, drv_o;
  logic [1:0]        ter;
  logic [7:0]        rclk, pdin, ndin, los, pout, nout;
  logic [7:0][1:0]   cts;
  rpc_bus_e          bus;
  int                mismatches, n_tests;
  rpc_strap u_strap (.sys_clk(sys_clk), .want(want), .drv(drv), .pins(pins), .drv_o(drv_o));
  rpc_top uut (
    .sys_clk(sys_clk), .arst_n(arst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .host_mode(host_mode), .rx_mute_enable(pins[0]), .rx_mute_enable_drv(drv_o[0]),
    .rx_ext_resistor_sel(pins[2:1]), .rx_ext_resistor_sel_drv(drv_o[1]),
    .termination_impedance_sel(ter), .rx_clock_edge_sel(pins[3]),
    .rx_clock_edge_sel_drv(drv_o[2]), .tx_clock_edge_sel(pins[4]),
    .tx_clock_edge_sel_drv(drv_o[3]), .rx_rec_clk(rclk), .rx_pos_data_in(pdin),
    .rx_neg_data_in(ndin), .rx_loss_of_signal(los), .rx_pos_data_out(pout),
    .rx_neg_data_out(nout), .chan_ter_sel(cts), .host_bus_type_sel(bus),
    .reconfig_seen(reconfig));
  task automatic summarize();
    $display("Tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int i;
    @(posedge sys_clk);
    apb_req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (apb_rsp.pready !== 1'b1 && i < 50);
    if (apb_rsp.pready !== 1'b1) begin
      mismatches++;
      summarize();
    end
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : apb
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
    logic [31:0] d;
    logic        er;
    apb(1'b0, a, 32'h0, d, er);
    chk(d, e, m);
    chk({31'h0, er}, 32'h0, m);
  endtask : rd_chk
  task automatic strap(input logic [4:0] w, input logic [3:0] d);
    @(posedge sys_clk);
    want <= w;
    drv  <= d;
    repeat (3) @(posedge sys_clk);
  endtask : strap
  task automatic edge_to(input logic lvl, input logic [7:0] d);
    @(posedge sys_clk);
    rclk <= {8{lvl}};
    pdin <= d;
    ndin <= ~d;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : edge_to
  task automatic t_regs();
    logic [31:0] d;
    logic        er;
    chk(32'(bus), 32'h1, "bus reset");
    rd_chk(8'h20, 32'h1, "ctrl reset");
    rd_chk(8'h00, 32'h0, "cfg reset");
    apb(1'b0, 8'h3c, 32'h0, d, er);
    chk(d, 32'h0, "unmapped data");
    chk({31'h0, er}, 32'h1, "unmapped error");
    $display("t_regs done");
  endtask : t_regs
  task automatic t_mute();
    logic [7:0] m;
    los <= 8'h0f;
    for (int k = 0; k < 3; k++) begin
      strap({4'h0, k == 1}, {3'b000, k != 0});
      m = (k == 2) ? 8'hff : 8'hf0;
      edge_to(1'b0, 8'h00);
      edge_to(1'b1, 8'h96);
      chk({16'h0, pout, nout}, {16'h0, 8'h96 & m, 8'h69 & m}, "mute");
      rd_chk(8'h24, {16'h0, (k == 2) ? 8'h00 : 8'h0f, 8'h0f}, "status");
    end
    $display("t_mute done");
  endtask : t_mute
  task automatic t_edge();
    strap(5'h00, 4'h1);
    los <= 8'h00;
    edge_to(1'b0, 8'h00);
    edge_to(1'b1, 8'ha5);
    chk({16'h0, pout, nout}, 32'ha55a, "rise");
    edge_to(1'b0, 8'h3c);
    chk({16'h0, pout, nout}, 32'ha55a, "fall ignored");
    strap(5'h08, 4'h5);
    edge_to(1'b1, 8'h0f);
    chk({16'h0, pout, nout}, 32'ha55a, "rise ignored");
    edge_to(1'b0, 8'h0f);
    chk({16'h0, pout, nout}, 32'h0ff0, "fall");
    $display("t_edge done");
  endtask : t_edge
  task automatic t_imp();
    int rx[4] = '{0, 240, 210, 150};
    int rt[4] = '{75, 100, 110, 120};
    int e;
    @(posedge sys_clk);
    for (int r = 0; r < 5; r++) begin
      for (int t = 0; t < 4; t++) begin
        ter <= t[1:0];
        strap({2'b00, r[1:0], 1'b0}, {2'b00, r < 4, 1'b0});
        e = (r % 4 == 0) ? rt[t] : rx[r % 4] * rt[t] / (rx[r % 4] - rt[t]);
        rd_chk(8'h40, e, "imp");
      end
    end
    $display("t_imp done");
  endtask : t_imp
  task automatic t_host();
    logic [31:0] d;
    logic        er;
    host_mode <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      strap({c[1], c[0], 2'b01, 1'b0}, 4'hf);
      chk(32'(bus), 32'h1 << c, "bus type");
    end
    apb(1'b1, 8'h0c, 32'h6, d, er);
    rd_chk(8'h4c, 210 * 100 / 110, "host imp");
    rd_chk(8'h40, 75, "host imp ch0");
    chk({30'h0, cts[3]}, 32'h1, "host ter");
    apb(1'b1, 8'h20, 32'h2, d, er);
    rd_chk(8'h20, 32'h2, "host ctrl");
    edge_to(1'b1, 8'h33);
    chk({16'h0, pout, nout}, 32'h0ff0, "host rise ignored");
    edge_to(1'b0, 8'h33);
    chk({16'h0, pout, nout}, 32'h33cc, "host fall");
    $display("t_host done");
  endtask : t_host
  task automatic t_recfg();
    logic [31:0] d;
    logic        er;
    rd_chk(8'h28, 32'h83, "mode");
    apb(1'b1, 8'h28, 32'h2, d, er);
    rd_chk(8'h28, 32'h81, "flag cleared");
    host_mode <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd_chk(8'h28, 32'h82, "flag set");
    $display("t_recfg done");
  endtask : t_recfg
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    {arst_n, host_mode, want, drv, ter, rclk, pdin, ndin, los} = '0;
    apb_req = '0;
    mismatches = 0;
    n_tests = 0;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_regs();
    t_mute();
    t_edge();
    t_imp();
    t_host();
    t_recfg();
    summarize();
  end
endmodule : tb_rpc_top
bind rpc_top rpc_monitor u_mon (
  .sys_clk, .arst_n, .host_mode, .rx_mute_enable, .rx_mute_enable_drv,
  .rx_clock_edge_sel, .rx_clock_edge_sel_drv, .tx_clock_edge_sel,
  .tx_clock_edge_sel_drv, .rx_rec_clk, .rx_pos_data_in, .rx_neg_data_in,
  .rx_loss_of_signal, .rx_pos_data_out, .rx_neg_data_out, .host_bus_type_sel,
  .reconfig_seen);
